// ---- rtl/mem_pin_pkg.sv ----
// Package for the shared memory pin control block
package mem_pin_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int SD_HI_MSB = 19;
  localparam int SD_HI_LSB = 16;
  localparam int SD_LO_MSB = 14;
  localparam int SD_LO_LSB = 5;
  localparam int STYLE_BIT = 19;
  localparam logic STYLE_SWITCH = 1'b1;
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_8 = 2'h2;
  localparam logic [ADDR_W-1:0] STRAP_RESET = 20'hfffff;
  localparam logic ISOLATE_RESET = 1'b1;

  // Owner of the shared pins in the current cycle
  typedef enum logic [2:0] {
    OWN_IDLE = 3'b001,
    OWN_SDRAM = 3'b010,
    OWN_EXT = 3'b100
  } owner_t;

  // Request from the SDRAM controller
  typedef struct packed {
    logic valid;
    logic write;
    logic [13:0] row_col;
    logic row_bit_ten;
    logic [DATA_W-1:0] wdata;
  } sdram_req_t;

  // Request from the external bus controller
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] width;
    logic [ADDR_W+1:0] byte_addr;
    logic [DATA_W-1:0] wdata;
  } ext_req_t;

  // Shared pin drive set; enables active low
  typedef struct packed {
    logic [ADDR_W-1:0] addr_out;
    logic [ADDR_W-1:0] addr_oe_n;
    logic row_ten_out;
    logic row_ten_oe_n;
    logic [DATA_W-1:0] data_out;
    logic [DATA_W-1:0] data_oe_n;
  } pin_drive_t;
endpackage

// ---- rtl/pin_sync.sv ----
// Two flip-flop synchroniser for pin inputs
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage read only by second; no reset, so pin levels keep
  // flowing through while reset is held
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// ---- rtl/shared_memory_pin_control.sv ----
// Shared memory pin control: straps, SDRAM and external bus pin muxing
module shared_memory_pin_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [mem_pin_pkg::ADDR_W-1:0] addr_in,
  input wire logic row_ten_in,
  input wire logic [mem_pin_pkg::DATA_W-1:0] data_in,
  input wire mem_pin_pkg::sdram_req_t sdram_req,
  input wire mem_pin_pkg::ext_req_t ext_req,
  output mem_pin_pkg::pin_drive_t pins,
  output logic bus_isolation_control,
  output logic [mem_pin_pkg::ADDR_W-1:0] boot_straps,
  output logic row_ten_strap,
  output logic switch_style,
  output logic [mem_pin_pkg::DATA_W-1:0] read_data,
  output logic sdram_grant,
  output logic ext_grant
);
  import mem_pin_pkg::*;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_sync;
  logic row_ten_sync;
  logic [DATA_W-1:0] data_sync;

  // The synchroniser keeps sampling while reset is held, so the strap
  // levels on the pins are already settled when reset is released
  pin_sync #(.W(ADDR_W + 1 + DATA_W)) u_sync (
    .clk(clk),
    .d({addr_in, row_ten_in, data_in}),
    .q({addr_sync, row_ten_sync, data_sync})
  );

  // ----------------------------------------------------------------
  // Strap capture and output release
  // ----------------------------------------------------------------
  logic released;
  logic [ADDR_W-1:0] straps;
  logic row_strap;

  // strap capture on the first edge after reset release
  // The first edge after release still sees the reset-time pin levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      released <= 1'b0;
      straps <= STRAP_RESET;
      row_strap <= 1'b1;
    end else if (!released) begin
      released <= 1'b1;
      straps <= addr_sync;
      row_strap <= row_ten_sync;
    end
  end

  assign boot_straps = straps;
  assign row_ten_strap = row_strap;
  // isolation style chosen by strap bit
  assign switch_style = straps[STYLE_BIT] == STYLE_SWITCH;

  // switch style also connects the bus for SDRAM writes
  // Buffer style keeps the bus separated through every SDRAM cycle
  logic switch_write;
  assign switch_write = switch_style && sdram_req.write;

  // ----------------------------------------------------------------
  // Ownership: SDRAM wins over the external bus
  // ----------------------------------------------------------------
  owner_t owner;
  owner_t next_owner;

  assign next_owner = !released ? OWN_IDLE :
                      sdram_req.valid ? OWN_SDRAM :
                      ext_req.valid ? OWN_EXT : OWN_IDLE;
  assign sdram_grant = released && sdram_req.valid;
  assign ext_grant = released && !sdram_req.valid && ext_req.valid;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] sdram_addr;
  wire [ADDR_W-1:0] ext_addr;
  wire [ADDR_W+1:0] ba = ext_req.byte_addr;

  // SDRAM address split around bit 15
  assign sdram_addr = {sdram_req.row_col[13:10], 1'b0,
                       sdram_req.row_col[9:0], 5'h00};
  // word, half or byte address by bus width
  assign ext_addr = (ext_req.width == WIDTH_32) ? ba[ADDR_W+1:2] :
                    (ext_req.width == WIDTH_16) ? ba[ADDR_W:1] :
                    ba[ADDR_W-1:0];

  // ----------------------------------------------------------------
  // Registered pin drive
  // ----------------------------------------------------------------
  pin_drive_t next_pins;
  logic next_iso;
  logic ext_wr;

  assign ext_wr = ext_req.write;

  always_comb begin
    next_pins = '{addr_out: '0, addr_oe_n: '0, row_ten_out: 1'b0,
                  row_ten_oe_n: 1'b0, data_out: '0, data_oe_n: '1};
    next_iso = ISOLATE_RESET;
    unique case (next_owner)
      OWN_SDRAM: begin
        next_pins.addr_out = sdram_addr;
        next_pins.row_ten_out = sdram_req.row_bit_ten;
        next_pins.data_out = sdram_req.wdata;
        next_pins.data_oe_n = {DATA_W{!sdram_req.write}};
        // analog switches pass the write through to the bus
        next_iso = !switch_write;
      end
      OWN_EXT: begin
        next_pins.addr_out = ext_addr;
        next_pins.data_out = ext_req.wdata;
        next_pins.data_oe_n = {DATA_W{!ext_wr}};
        // connect external devices for the whole access
        next_iso = 1'b0;
      end
      OWN_IDLE: begin
        next_pins.addr_oe_n = released ? '0 : '1;
        next_pins.row_ten_oe_n = !released;
      end
    endcase
  end

  // all pins inputs, isolation high during reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      owner <= OWN_IDLE;
      pins <= '{addr_out: '0, addr_oe_n: '1, row_ten_out: 1'b0,
                row_ten_oe_n: 1'b1, data_out: '0, data_oe_n: '1};
      bus_isolation_control <= ISOLATE_RESET;
      read_data <= '0;
    end else begin
      owner <= next_owner;
      pins <= next_pins;
      bus_isolation_control <= next_iso;
      read_data <= data_sync;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_reset_held;
    !rst_n ##1 !rst_n;
  endsequence

  sequence s_switch_write;
    sdram_grant && switch_write;
  endsequence

  // Reset-time pin direction
  a_addr_input_reset: assert property (@(posedge clk)
    s_reset_held |-> pins.addr_oe_n == '1)
    else $error("address pins driven during reset");
  a_row_input_reset: assert property (@(posedge clk)
    s_reset_held |-> pins.row_ten_oe_n)
    else $error("row bit ten driven during reset");
  a_data_input_reset: assert property (@(posedge clk)
    !rst_n |=> pins.data_oe_n == '1)
    else $error("data driven during reset");
  a_strap_capture: assert property (@(posedge clk) disable iff (!rst_n)
    !released |=> straps == $past(addr_sync))
    else $error("straps not captured");
  a_addr_out_after: assert property (@(posedge clk) disable iff (!rst_n)
    released |=> pins.addr_oe_n == '0 && !pins.row_ten_oe_n)
    else $error("address pins not output after reset");
  a_sdram_addr: assert property (@(posedge clk) disable iff (!rst_n)
    sdram_grant |=> pins.addr_out[SD_HI_MSB:SD_HI_LSB] ==
      $past(sdram_req.row_col[13:10]) &&
      pins.row_ten_out == $past(sdram_req.row_bit_ten))
    else $error("sdram address wrong");
  a_ext_word_addr: assert property (@(posedge clk) disable iff (!rst_n)
    ext_grant && ext_req.width == WIDTH_32 |=>
      pins.addr_out == $past(ext_req.byte_addr[ADDR_W+1:2]))
    else $error("external word address wrong");
  // Isolation output
  a_iso_connect: assert property (@(posedge clk) disable iff (!rst_n)
    ext_grant |=> !bus_isolation_control)
    else $error("isolation not lowered for external access");
  a_iso_separate: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_grant && !(sdram_grant && switch_write) |=> bus_isolation_control)
    else $error("isolation low without external access");
  a_iso_switch_wr: assert property (@(posedge clk) disable iff (!rst_n)
    s_switch_write |=> !bus_isolation_control)
    else $error("switch style write not connected");
  a_iso_reset: assert property (@(posedge clk)
    !rst_n |=> bus_isolation_control)
    else $error("isolation not high from reset");

  // Remaining address, grant and read paths
  a_sdram_lo_addr: assert property (@(posedge clk) disable iff (!rst_n)
    sdram_grant |=> pins.addr_out[SD_LO_MSB:SD_LO_LSB] ==
      $past(sdram_req.row_col[9:0]))
    else $error("sdram column address wrong");
  a_ext_half_addr: assert property (@(posedge clk) disable iff (!rst_n)
    ext_grant && ext_req.width == WIDTH_16 |=>
      pins.addr_out == $past(ext_req.byte_addr[ADDR_W:1]))
    else $error("external half address wrong");
  a_ext_byte_addr: assert property (@(posedge clk) disable iff (!rst_n)
    ext_grant && ext_req.width == WIDTH_8 |=>
      pins.addr_out == $past(ext_req.byte_addr[ADDR_W-1:0]))
    else $error("external byte address wrong");
  a_no_grant_early: assert property (@(posedge clk) disable iff (!rst_n)
    !released |-> !sdram_grant && !ext_grant)
    else $error("grant before pins released");
  a_read_path: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> read_data == $past(data_sync))
    else $error("read data not from data pins");
  a_owner_track: assert property (@(posedge clk) disable iff (!rst_n)
    sdram_grant |=> owner == OWN_SDRAM)
    else $error("sdram not owner after grant");
endmodule

// ---- verification/mem_pin_pads.sv ----
// Pad model: strap resistors and pull-ups on shared pins
module mem_pin_pads #(
  parameter logic [19:0] STRAPS = 20'hfffff
) (
  input wire mem_pin_pkg::pin_drive_t pins,
  output logic [mem_pin_pkg::ADDR_W-1:0] addr_in,
  output logic row_ten_in,
  output logic [mem_pin_pkg::DATA_W-1:0] data_in
);
  import mem_pin_pkg::*;
  // Undriven address pins settle to their strap resistor level
  assign addr_in = (pins.addr_out & ~pins.addr_oe_n)
                 | (STRAPS & pins.addr_oe_n);
  assign row_ten_in = pins.row_ten_oe_n ? 1'b1 : pins.row_ten_out;
  // Released data lines go to their pull-up level
  assign data_in = (pins.data_out & ~pins.data_oe_n) | pins.data_oe_n;
endmodule

// ---- verification/tb_shared_memory_pin_control.sv ----
// Testbench for the shared memory pin control block
module tb_shared_memory_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_pin_pkg::*;
  localparam logic [19:0] STRAPS = 20'ha5a5a;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr_in, boot_straps;
  logic row_ten_in, iso, sw, ten_strap, sd_gnt, ext_gnt;
  logic [DATA_W-1:0] data_in, read_data;
  sdram_req_t sdram_req = '0;
  ext_req_t ext_req = '0;
  pin_drive_t pins;
  int fail_count = 0;
  int compares = 0;

  // Free running 25 MHz clock
  always #20 clk = ~clk;

  shared_memory_pin_control u_dut (.clk(clk), .rst_n(rst_n),
    .addr_in(addr_in), .row_ten_in(row_ten_in), .data_in(data_in),
    .sdram_req(sdram_req), .ext_req(ext_req), .pins(pins),
    .bus_isolation_control(iso), .boot_straps(boot_straps),
    .row_ten_strap(ten_strap), .switch_style(sw),
    .read_data(read_data), .sdram_grant(sd_gnt), .ext_grant(ext_gnt));
  mem_pin_pads #(.STRAPS(STRAPS)) u_pads (.pins(pins),
    .addr_in(addr_in), .row_ten_in(row_ten_in), .data_in(data_in));

  // ----------------------------------------
  // Checking and scenarios
  // ----------------------------------------
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pins are inputs in reset, straps captured on release
  task automatic t_reset();
    repeat (11) @(posedge clk);
    #1 chk("addr oe in reset", 20'hfffff, pins.addr_oe_n);
    chk("row ten oe in reset", 1, pins.row_ten_oe_n);
    chk("data oe in reset", 32'hffffffff, pins.data_oe_n);
    chk("iso in reset", 1, iso);
    @(posedge clk) rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("straps", STRAPS, boot_straps);
    chk("row ten strap", 1, ten_strap);
    chk("style", STRAPS[STYLE_BIT], sw);
    chk("addr oe after", 0, pins.addr_oe_n);
    chk("row ten oe after", 0, pins.row_ten_oe_n);
    chk("iso after", 1, iso);
    $display("test reset done");
  endtask

  // SDRAM write or read beats a competing external request
  task automatic t_sdram(input logic wr);
    @(posedge clk) begin
      sdram_req <= '{1'b1, wr, 14'h2c3b, 1'b0, 32'h12345678};
      ext_req <= '{1'b1, 1'b1, WIDTH_8, 22'h2abcde, 32'h0};
    end
    @(posedge clk);
    #1 chk("ext refused", 0, ext_gnt);
    chk("sd grant", 1, sd_gnt);
    @(posedge clk);
    #1 chk("sd hi addr", 4'hb, pins.addr_out[19:16]);
    chk("sd lo addr", 10'h03b, pins.addr_out[14:5]);
    chk("sd row ten", 0, {pins.row_ten_out, pins.row_ten_oe_n});
    chk("sd data", 32'h12345678, pins.data_out);
    chk("sd data oe", {32{~wr}}, pins.data_oe_n);
    chk("sd iso", !(STRAPS[STYLE_BIT] && wr), iso);
    @(posedge clk) begin
      sdram_req <= '0;
      ext_req <= '0;
    end
    @(posedge clk);
    #1 chk("sd read", wr ? 32'h12345678 : '1, read_data);
    $display("test sdram write %0d done", wr);
  endtask

  // External access for one width, then release
  task automatic t_ext(input logic [1:0] w, input logic wr,
                       input logic [19:0] exp);
    @(posedge clk) ext_req <= '{1'b1, wr, w, 22'h2abcde, 32'h0f0f0f0f};
    repeat (2) @(posedge clk);
    #1 chk("ext addr", exp, pins.addr_out);
    chk("ext iso", 0, iso);
    chk("ext data oe", {32{~wr}}, pins.data_oe_n);
    @(posedge clk) ext_req <= '0;
    @(posedge clk);
    #1 chk("iso idle", 1, iso);
    chk("data oe idle", 32'hffffffff, pins.data_oe_n);
    $display("test ext width %0d done", w);
  endtask

  // Print counts and verdict, then stop
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_sdram(1'b1);
    t_sdram(1'b0);
    t_ext(WIDTH_32, 1'b1, 20'haaf37);
    t_ext(WIDTH_16, 1'b0, 20'h55e6f);
    t_ext(WIDTH_8, 1'b1, 20'habcde);
    finish_test();
  end
endmodule
